// file: rtl/sba_alu.v
// signed two's-complement arithmetic unit with flags and a small register port
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// How it works
// [RQ1] operands and results are two's complement, MSB sign
// [RQ2] one word spans 8000 to 7FFF hex
// [RQ3] two words span 8000 0000 to 7FFF FFFF
// [RQ4] carry set on carry out of addition
// [RQ5] carry set on negative subtraction result
// [RQ6] equals set on zero add/sub/mul/div result
// [RQ7] equals set on zero negation result
// [RQ8] overflow set when 16-bit add/sub exceeds 7FFF
// [RQ9] overflow set when 32-bit add/sub exceeds limit
// [RQ10] underflow set when 16-bit result below 8000
// [RQ11] underflow set when 32-bit result below limit
// [RQ12] unmet flag conditions clear the flag each operation
// [RQ13] division returns quotient and remainder
// [RQ14] single-word operations take 16-bit operands only
// [RQ15] full build offers one- and two-word forms
// [RQ16] reduced build: single-word add and subtract only
// [RQ17] product is twice the operand width
// [RQ18] flags change only when an operation completes
`include "sba_regs.vh"

module sba_alu #(
    parameter FULL_FEATURE = 1'b1
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // operation request from the sequencer
    input wire op_valid_i,
    input wire [3:0] op_code_i,
    input wire [31:0] opnd_a_i,
    input wire [31:0] opnd_b_i,
    // results and flags
    output reg res_valid_o,
    output reg [31:0] res_lo_o,
    output reg [31:0] res_hi_o,
    output reg op_err_o,
    output reg busy_o,
    output reg flag_carry_o,
    output reg flag_equal_o,
    output reg flag_ovf_o,
    output reg flag_unf_o,
    // register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // interrupt
    output reg irq_o
);

    // ********
    // helpers
    // ********

    // sign extension of a one-word value to two words
    function [31:0] sx16;
        input [15:0] v;
        begin
            sx16 = {{16{v[15]}}, v}; // [RQ1]
        end
    endfunction

    // true when the opcode names a two-word form
    function is_dw;
        input [3:0] op;
        begin
            is_dw = (op == `SBA_OP_DW_NEGATE) || (op == `SBA_OP_DW_ADD) ||
                    (op == `SBA_OP_DW_SUB) || (op == `SBA_OP_DW_MUL) ||
                    (op == `SBA_OP_DW_DIV);
        end
    endfunction

    // true when the opcode exists in this build
    function op_legal;
        input [3:0] op;
        begin
            if (FULL_FEATURE) begin
                op_legal = (op <= `SBA_OP_DW_DIV); // [RQ15]
            end else begin
                op_legal = (op == `SBA_OP_SW_ADD) || (op == `SBA_OP_SW_SUB); // [RQ16]
            end
        end
    endfunction

    // ********
    // state machine codes
    // ********
    localparam ST_IDLE = 2'b00; // waiting for an operation
    localparam ST_DIV = 2'b01; // divider stepping
    localparam ST_FIN = 2'b10; // divider sign fix-up

    // ********
    // combinational datapath
    // ********
    wire [15:0] a16 = opnd_a_i[15:0]; // one-word operands use low half [RQ14]
    wire [15:0] b16 = opnd_b_i[15:0];
    wire [16:0] add16_u = {1'b0, a16} + {1'b0, b16}; // unsigned carry out
    wire [16:0] add16_s = {a16[15], a16} + {b16[15], b16}; // exact signed sum
    wire [16:0] sub16_s = {a16[15], a16} - {b16[15], b16}; // exact signed diff
    wire [15:0] neg16 = 16'h0000 - a16;
    wire [32:0] add32_u = {1'b0, opnd_a_i} + {1'b0, opnd_b_i};
    wire [32:0] add32_s = {opnd_a_i[31], opnd_a_i} + {opnd_b_i[31], opnd_b_i};
    wire [32:0] sub32_s = {opnd_a_i[31], opnd_a_i} - {opnd_b_i[31], opnd_b_i};
    wire [31:0] neg32 = 32'h00000000 - opnd_a_i;
    wire signed [31:0] mul16 = $signed(a16) * $signed(b16); // [RQ17]
    wire signed [63:0] mul32 = $signed(opnd_a_i) * $signed(opnd_b_i); // [RQ17]
    // divider magnitudes
    wire [15:0] amag16 = a16[15] ? neg16 : a16;
    wire [15:0] bmag16 = b16[15] ? (16'h0000 - b16) : b16;
    wire [31:0] amag32 = opnd_a_i[31] ? neg32 : opnd_a_i;
    wire [31:0] bmag32 = opnd_b_i[31] ? (32'h00000000 - opnd_b_i) : opnd_b_i;

    reg [31:0] res_lo_d; // next low result word
    reg [31:0] res_hi_d; // next high result word
    reg carry_d; // next flag values
    reg equal_d;
    reg ovf_d;
    reg unf_d;

    // result and flags of every single-cycle operation; every flag gets a
    // value on every path so nothing lingers from an earlier operation
    always @* begin
        res_lo_d = 32'h00000000;
        res_hi_d = 32'h00000000;
        carry_d = 1'b0; // [RQ12]
        equal_d = 1'b0; // [RQ12]
        ovf_d = 1'b0; // [RQ12]
        unf_d = 1'b0; // [RQ12]
        case (op_code_i)
            `SBA_OP_SW_NEGATE: begin
                res_lo_d = sx16(neg16);
                res_hi_d = {32{neg16[15]}};
                equal_d = (neg16 == 16'h0000); // [RQ7]
                unf_d = (a16 == `SBA_MIN16); // [RQ10] [RQ2]
            end
            `SBA_OP_SW_ADD: begin
                res_lo_d = sx16(add16_s[15:0]);
                res_hi_d = {32{add16_s[15]}};
                carry_d = add16_u[16]; // [RQ4]
                equal_d = (add16_s[15:0] == 16'h0000); // [RQ6]
                ovf_d = ~add16_s[16] & add16_s[15]; // [RQ8]
                unf_d = add16_s[16] & ~add16_s[15]; // [RQ10]
            end
            `SBA_OP_SW_SUB: begin
                res_lo_d = sx16(sub16_s[15:0]);
                res_hi_d = {32{sub16_s[15]}};
                carry_d = sub16_s[16]; // [RQ5]
                equal_d = (sub16_s[15:0] == 16'h0000); // [RQ6]
                ovf_d = ~sub16_s[16] & sub16_s[15]; // [RQ8]
                unf_d = sub16_s[16] & ~sub16_s[15]; // [RQ10]
            end
            `SBA_OP_SW_MUL: begin
                res_lo_d = mul16; // full 32-bit product
                res_hi_d = {32{mul16[31]}};
                equal_d = (mul16 == 32'h00000000); // [RQ6]
            end
            `SBA_OP_DW_NEGATE: begin
                res_lo_d = neg32;
                res_hi_d = {32{neg32[31]}};
                equal_d = (neg32 == 32'h00000000); // [RQ7]
                unf_d = (opnd_a_i == `SBA_MIN32); // [RQ11] [RQ3]
            end
            `SBA_OP_DW_ADD: begin
                res_lo_d = add32_s[31:0];
                res_hi_d = {32{add32_s[31]}};
                carry_d = add32_u[32]; // [RQ4]
                equal_d = (add32_s[31:0] == 32'h00000000); // [RQ6]
                ovf_d = ~add32_s[32] & add32_s[31]; // [RQ9]
                unf_d = add32_s[32] & ~add32_s[31]; // [RQ11]
            end
            `SBA_OP_DW_SUB: begin
                res_lo_d = sub32_s[31:0];
                res_hi_d = {32{sub32_s[31]}};
                carry_d = sub32_s[32]; // [RQ5]
                equal_d = (sub32_s[31:0] == 32'h00000000); // [RQ6]
                ovf_d = ~sub32_s[32] & sub32_s[31]; // [RQ9]
                unf_d = sub32_s[32] & ~sub32_s[31]; // [RQ11]
            end
            `SBA_OP_DW_MUL: begin
                res_lo_d = mul32[31:0]; // 64-bit product, low word
                res_hi_d = mul32[63:32];
                equal_d = (mul32 == 64'h0000000000000000); // [RQ6]
            end
            default: begin
                // division results come from the divider; zero divisor answers zero
                equal_d = 1'b1; // [RQ6]
            end
        endcase
    end

    // ********
    // request acceptance
    // ********
    reg [1:0] state_q; // sequencer state
    wire accept = op_valid_i && (state_q == ST_IDLE); // requests while busy are dropped
    wire legal = op_legal(op_code_i);
    wire dbl = is_dw(op_code_i);
    wire is_div = (op_code_i == `SBA_OP_SW_DIV) || (op_code_i == `SBA_OP_DW_DIV);
    wire divz = dbl ? (opnd_b_i == 32'h00000000) : (b16 == 16'h0000);

    // ********
    // divider: restoring, one quotient bit per cycle on magnitudes
    // ********
    reg [5:0] div_cnt_q; // steps left
    reg div_dbl_q; // two-word division in progress
    reg div_qneg_q; // quotient takes a minus sign
    reg div_rneg_q; // remainder follows the dividend sign
    reg [32:0] div_r_q; // partial remainder
    reg [31:0] div_q_q; // dividend shifting out, quotient shifting in
    reg [31:0] div_d_q; // divisor magnitude
    wire [32:0] div_shift = {div_r_q[31:0], div_q_q[31]};
    wire [32:0] div_trial = div_shift - {1'b0, div_d_q};
    wire [31:0] qmag = div_dbl_q ? div_q_q : {16'h0000, div_q_q[15:0]};
    wire [31:0] rmag = div_r_q[31:0];
    wire [31:0] quot = div_qneg_q ? (32'h00000000 - qmag) : qmag;
    wire [31:0] remd = div_rneg_q ? (32'h00000000 - rmag) : rmag;
    wire [31:0] quot_o = div_dbl_q ? quot : sx16(quot[15:0]);
    wire [31:0] remd_o = div_dbl_q ? remd : sx16(remd[15:0]);

    // ********
    // register port state
    // ********
    reg [4:0] status_q; // sticky events
    reg [4:0] mask_q; // interrupt enables
    reg [4:0] evt; // events raised this cycle

    // event vector for the status register
    always @* begin
        evt = 5'h00;
        if (accept && !legal) begin
            evt[`SBA_EVT_ILLEGAL] = 1'b1;
        end else if (accept && !(is_div && !divz)) begin
            evt[`SBA_EVT_DONE] = 1'b1;
            evt[`SBA_EVT_OVF] = ovf_d && !is_div;
            evt[`SBA_EVT_UNF] = unf_d && !is_div;
            evt[`SBA_EVT_DIVZ] = is_div;
        end else if (state_q == ST_FIN) begin
            evt[`SBA_EVT_DONE] = 1'b1;
        end
    end

    wire wr_status = reg_wr_i && (reg_addr_i == `SBA_REG_STATUS);
    wire wr_mask = reg_wr_i && (reg_addr_i == `SBA_REG_MASK);
    // set beats a simultaneous write-one clear
    wire [4:0] status_d = (status_q & ~(wr_status ? reg_wdata_i[4:0] : 5'h00)) | evt;
    wire [4:0] mask_d = wr_mask ? reg_wdata_i[4:0] : mask_q;

    // ********
    // main sequencer, results and flags
    // ********
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            res_valid_o <= 1'b0;
            res_lo_o <= 32'h00000000;
            res_hi_o <= 32'h00000000;
            op_err_o <= 1'b0;
            busy_o <= 1'b0;
            flag_carry_o <= 1'b0;
            flag_equal_o <= 1'b0;
            flag_ovf_o <= 1'b0;
            flag_unf_o <= 1'b0;
            div_cnt_q <= 6'h00;
            div_dbl_q <= 1'b0;
            div_qneg_q <= 1'b0;
            div_rneg_q <= 1'b0;
            div_r_q <= 33'h000000000;
            div_q_q <= 32'h00000000;
            div_d_q <= 32'h00000000;
        end else begin
            res_valid_o <= 1'b0;
            op_err_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (accept && !legal) begin
                        op_err_o <= 1'b1; // refused, flags untouched [RQ18]
                    end else if (accept && is_div && !divz) begin
                        // load divider; one word sits in the upper half
                        state_q <= ST_DIV;
                        busy_o <= 1'b1;
                        div_dbl_q <= dbl;
                        div_r_q <= 33'h000000000;
                        div_q_q <= dbl ? amag32 : {amag16, 16'h0000};
                        div_d_q <= dbl ? bmag32 : {16'h0000, bmag16};
                        div_cnt_q <= dbl ? `SBA_DIV_STEPS_DW : `SBA_DIV_STEPS_SW;
                        div_qneg_q <= dbl ? (opnd_a_i[31] ^ opnd_b_i[31]) : (a16[15] ^ b16[15]);
                        div_rneg_q <= dbl ? opnd_a_i[31] : a16[15];
                    end else if (accept) begin
                        // single-cycle operation, flags refreshed together [RQ18]
                        res_valid_o <= 1'b1;
                        res_lo_o <= res_lo_d;
                        res_hi_o <= res_hi_d;
                        flag_carry_o <= carry_d; // [RQ12]
                        flag_equal_o <= equal_d;
                        flag_ovf_o <= ovf_d;
                        flag_unf_o <= unf_d;
                    end
                end
                ST_DIV: begin
                    // one restoring step
                    if (!div_trial[32]) begin
                        div_r_q <= div_trial;
                        div_q_q <= {div_q_q[30:0], 1'b1};
                    end else begin
                        div_r_q <= div_shift;
                        div_q_q <= {div_q_q[30:0], 1'b0};
                    end
                    div_cnt_q <= div_cnt_q - 6'h01;
                    if (div_cnt_q == 6'h01) begin
                        state_q <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    // apply signs, publish quotient and remainder [RQ13]
                    state_q <= ST_IDLE;
                    busy_o <= 1'b0;
                    res_valid_o <= 1'b1;
                    res_lo_o <= quot_o;
                    res_hi_o <= remd_o;
                    flag_carry_o <= 1'b0; // [RQ12]
                    flag_equal_o <= (quot_o == 32'h00000000); // [RQ6] [RQ18]
                    flag_ovf_o <= 1'b0;
                    flag_unf_o <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

    // ********
    // status, mask, interrupt and read data
    // ********
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= `SBA_STATUS_RST;
            mask_q <= `SBA_MASK_RST;
            irq_o <= 1'b0;
            reg_rdata_o <= 32'h00000000;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_o <= |(status_d & mask_d); // level while any unmasked bit set
            reg_rdata_o <= 32'h00000000;
            if (reg_rd_i) begin
                // address decode, unmapped reads return zero
                if (reg_addr_i == `SBA_REG_STATUS) begin
                    reg_rdata_o <= {27'h0000000, status_q};
                end else if (reg_addr_i == `SBA_REG_MASK) begin
                    reg_rdata_o <= {27'h0000000, mask_q};
                end else if (reg_addr_i == `SBA_REG_FLAGS) begin
                    reg_rdata_o[`SBA_FLG_CARRY] <= flag_carry_o;
                    reg_rdata_o[`SBA_FLG_EQUAL] <= flag_equal_o;
                    reg_rdata_o[`SBA_FLG_OVF] <= flag_ovf_o;
                    reg_rdata_o[`SBA_FLG_UNF] <= flag_unf_o;
                    reg_rdata_o[`SBA_FLG_BUSY] <= busy_o;
                    reg_rdata_o[`SBA_FLG_FULL] <= FULL_FEATURE;
                end
            end
        end
    end

endmodule // sba_alu

// file: rtl/sba_regs.vh
// constants for the signed binary arithmetic unit
`ifndef SBA_REGS_VH
`define SBA_REGS_VH

// ********
// operation codes presented on op_code_i
// ********
`define SBA_OP_W 4
`define SBA_OP_SW_NEGATE 4'h0
`define SBA_OP_SW_ADD 4'h1
`define SBA_OP_SW_SUB 4'h2
`define SBA_OP_SW_MUL 4'h3
`define SBA_OP_SW_DIV 4'h4
`define SBA_OP_DW_NEGATE 4'h5
`define SBA_OP_DW_ADD 4'h6
`define SBA_OP_DW_SUB 4'h7
`define SBA_OP_DW_MUL 4'h8
`define SBA_OP_DW_DIV 4'h9

// ********
// signed limits of one-word and two-word values
// ********
`define SBA_MIN16 16'h8000
`define SBA_MAX16 16'h7FFF
`define SBA_MIN32 32'h80000000
`define SBA_MAX32 32'h7FFFFFFF

// ********
// divider step counts
// ********
`define SBA_CNT_W 6
`define SBA_DIV_STEPS_SW 6'h10
`define SBA_DIV_STEPS_DW 6'h20

// ********
// register offsets (byte addresses on the register port)
// ********
`define SBA_ADDR_W 4
`define SBA_REG_STATUS 4'h0
`define SBA_REG_MASK 4'h4
`define SBA_REG_FLAGS 4'h8

// ********
// status and mask bit positions
// ********
`define SBA_EVT_W 5
`define SBA_EVT_DONE 0
`define SBA_EVT_OVF 1
`define SBA_EVT_UNF 2
`define SBA_EVT_DIVZ 3
`define SBA_EVT_ILLEGAL 4
`define SBA_STATUS_RST 5'h00
`define SBA_MASK_RST 5'h00

// ********
// flags register bit positions
// ********
`define SBA_FLG_CARRY 0
`define SBA_FLG_EQUAL 1
`define SBA_FLG_OVF 2
`define SBA_FLG_UNF 3
`define SBA_FLG_BUSY 4
`define SBA_FLG_FULL 5

`endif

// file: tb/sba_alu_assertions.sv
// port-level checker for the signed arithmetic unit
`timescale 1ns/1ps
`include "sba_regs.vh"

module sba_alu_assertions (
    // clock and reset
    input logic clk_sys_i,
    input logic rst_n_i,
    // request side
    input logic op_valid_i,
    input logic [3:0] op_code_i,
    input logic [31:0] opnd_a_i,
    input logic [31:0] opnd_b_i,
    // result side
    input logic res_valid_o,
    input logic op_err_o,
    input logic busy_o,
    input logic flag_carry_o,
    input logic flag_equal_o,
    input logic flag_ovf_o,
    input logic flag_unf_o,
    // register port
    input logic reg_rd_i,
    input logic [31:0] reg_rdata_o
);
    // ****************************************************************
    // exact sums and differences at operand width plus one
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire take = op_valid_i && !busy_o; // request accepted
    wire [16:0] s16 = {opnd_a_i[15], opnd_a_i[15:0]} + {opnd_b_i[15], opnd_b_i[15:0]};
    wire [16:0] d16 = {opnd_a_i[15], opnd_a_i[15:0]} - {opnd_b_i[15], opnd_b_i[15:0]};
    wire [16:0] u16 = {1'b0, opnd_a_i[15:0]} + {1'b0, opnd_b_i[15:0]};
    wire [32:0] s32 = {opnd_a_i[31], opnd_a_i} + {opnd_b_i[31], opnd_b_i};
    sequence s_take(logic [3:0] c);
        take && op_code_i == c;
    endsequence
    sequence s_div;
        s_take(`SBA_OP_SW_DIV) ##0 opnd_b_i[15:0] != 16'h0000;
    endsequence
    sequence s_div_done;
        busy_o [*8] ##10 (res_valid_o && !busy_o);
    endsequence
    a_sw_ovf: assert property (s_take(`SBA_OP_SW_ADD) |=> res_valid_o &&
        flag_ovf_o == ($past(s16[16:15]) == 2'b01)) else $error("sw add overflow flag");
    a_sw_carry: assert property (s_take(`SBA_OP_SW_ADD) |=>
        flag_carry_o == $past(u16[16])) else $error("sw add carry flag");
    a_sub_carry: assert property (s_take(`SBA_OP_SW_SUB) |=> flag_carry_o == $past(d16[16])
        && flag_unf_o == ($past(d16[16:15]) == 2'b10)) else $error("sw sub carry or underflow");
    a_dw_limits: assert property (s_take(`SBA_OP_DW_ADD) |=>
        flag_ovf_o == ($past(s32[32:31]) == 2'b01) && flag_unf_o == ($past(s32[32:31]) == 2'b10))
        else $error("dw add limit flags");
    a_neg_flags: assert property (s_take(`SBA_OP_SW_NEGATE) |=>
        flag_equal_o == ($past(opnd_a_i[15:0]) == 16'h0000) &&
        flag_unf_o == ($past(opnd_a_i[15:0]) == 16'h8000)) else $error("negate flags");
    a_div_steps: assert property (s_div |=> s_div_done)
        else $error("sw divide latency");
    a_illegal_op: assert property (take && op_code_i >= 4'hA |=> op_err_o && !res_valid_o)
        else $error("illegal opcode not refused");
    a_flags_hold: assert property (!res_valid_o |->
        $stable({flag_carry_o, flag_equal_o, flag_ovf_o, flag_unf_o})) else $error("flags moved");
    a_rd_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
        else $error("read data outside read cycle");
endmodule // sba_alu_assertions

bind sba_alu sba_alu_assertions chk_u (.clk_sys_i, .rst_n_i, .op_valid_i, .op_code_i,
    .opnd_a_i, .opnd_b_i, .res_valid_o, .op_err_o, .busy_o, .flag_carry_o, .flag_equal_o,
    .flag_ovf_o, .flag_unf_o, .reg_rd_i, .reg_rdata_o);

// file: tb/sba_seq_model.sv
// instruction sequencer model issuing operations to the unit
`timescale 1ns/1ps

module sba_seq_model (
    // clock and unit status
    input logic clk_sys_i,
    input logic busy_i,
    // operation request
    output logic op_valid_o,
    output logic [3:0] op_code_o,
    output logic [31:0] opnd_a_o,
    output logic [31:0] opnd_b_o
);
    // ****************************************************************
    // request held until taken at an edge with the unit not busy
    // ****************************************************************
    initial begin
        op_valid_o = 1'b0;
        op_code_o = 4'h0;
        opnd_a_o = 32'h00000000;
        opnd_b_o = 32'h00000000;
    end
    task automatic issue(input logic [3:0] c, input logic [31:0] a, b, output logic tmo);
        int n;
        n = 0;
        op_valid_o <= 1'b1;
        op_code_o <= c;
        opnd_a_o <= a;
        opnd_b_o <= b;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (busy_i !== 1'b0 && n < 100);
        tmo = (busy_i !== 1'b0);
    endtask
    // released operands show inverted, stale values
    task automatic idle();
        op_valid_o <= 1'b0;
        opnd_a_o <= ~opnd_a_o;
        opnd_b_o <= ~opnd_b_o;
        @(posedge clk_sys_i);
    endtask
endmodule // sba_seq_model

// file: tb/tb_top.sv
// self-checking bench for the signed arithmetic unit
`timescale 1ns/1ps
`include "sba_regs.vh"

module tb_top;
    // ****************************************************************
    // signals, instances and expected-result queue
    // ****************************************************************
    typedef struct {logic [31:0] lo; logic [31:0] hi; logic [3:0] f;} sba_exp_t;
    logic clk_sys_i, rst_n_i, reg_wr, reg_rd, op_valid;
    logic [3:0] reg_addr, op_code;
    logic [31:0] reg_wdata, opnd_a, opnd_b, res_lo, res_hi, rdata, rnd;
    logic res_valid, op_err, busy, cy, eq, ov, un, irq;
    int mismatches, cmp_count, seed;
    sba_exp_t exp_q[$];
    sba_exp_t mon_e;
    sba_alu dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid),
        .op_code_i(op_code), .opnd_a_i(opnd_a), .opnd_b_i(opnd_b), .res_valid_o(res_valid),
        .res_lo_o(res_lo), .res_hi_o(res_hi), .op_err_o(op_err), .busy_o(busy),
        .flag_carry_o(cy), .flag_equal_o(eq), .flag_ovf_o(ov), .flag_unf_o(un),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .irq_o(irq));
    sba_seq_model seq_u (.clk_sys_i(clk_sys_i), .busy_i(busy), .op_valid_o(op_valid),
        .op_code_o(op_code), .opnd_a_o(opnd_a), .opnd_b_o(opnd_b));
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        cmp_count++;
        if (e !== s) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] sx(input logic sw, input logic [63:0] v);
        return sw ? {{16{v[15]}}, v[15:0]} : v[31:0];
    endfunction
    // reference result and flags {unf, ovf, equal, carry}
    function automatic void model(input logic [3:0] c, input logic [31:0] a, b,
            output logic [31:0] lo, hi, output logic [3:0] f);
        longint sa, sb, r, q, mx;
        logic sw, c0;
        logic [16:0] u1;
        logic [32:0] u2;
        sw = c < 4'h5;
        sa = sw ? longint'($signed(a[15:0])) : longint'($signed(a));
        sb = sw ? longint'($signed(b[15:0])) : longint'($signed(b));
        mx = sw ? 32767 : 2147483647;
        u1 = {1'b0, a[15:0]} + {1'b0, b[15:0]};
        u2 = {1'b0, a} + {1'b0, b};
        c0 = 1'b0;
        q = 0;
        r = 0;
        case (sw ? c : c - 4'h5)
            4'h0: r = -sa;
            4'h1: begin r = sa + sb; c0 = sw ? u1[16] : u2[32]; end
            4'h2: begin r = sa - sb; c0 = r < 0; end
            4'h3: r = sa * sb;
            default: if (sb != 0) begin q = sa / sb; r = sa % sb; end
        endcase
        if (c == `SBA_OP_SW_DIV || c == `SBA_OP_DW_DIV) begin lo = sx(sw, q); hi = sx(sw, r); end
        else if (c == `SBA_OP_SW_MUL || c == `SBA_OP_DW_MUL) {hi, lo} = r;
        else begin lo = sx(sw, r); hi = {32{lo[31]}}; end
        f[0] = c0;
        f[1] = (c == `SBA_OP_SW_MUL || c == `SBA_OP_DW_MUL) ? (r == 0) : (lo == 0);
        f[2] = (c == 4'h1 || c == 4'h2 || c == 4'h6 || c == 4'h7) && r > mx;
        f[3] = (c == 4'h0 || c == 4'h5) ? (sa == -mx - 1) :
            ((c == 4'h1 || c == 4'h2 || c == 4'h6 || c == 4'h7) && r < -mx - 1);
    endfunction
    task automatic run(input logic [3:0] c, input logic [31:0] a, b);
        sba_exp_t e;
        logic t;
        if (c < 4'hA) begin
            model(c, a, b, e.lo, e.hi, e.f);
            exp_q.push_back(e);
        end
        seq_u.issue(c, a, b, t);
        if (t) begin mismatches++; end_sim(); end
    endtask
    task automatic drain();
        int n;
        n = 0;
        seq_u.idle();
        while (exp_q.size() > 0 && n < 200) begin @(posedge clk_sys_i); n++; end
        if (exp_q.size() > 0) begin mismatches++; end_sim(); end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [3:0] ad, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        @(posedge clk_sys_i);
        chk("reg_rdata", e, rdata);
    endtask
    // ****************************************************************
    // result watcher: oldest note against each completed result
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("res_valid", 32'h0, 32'h1);
            else begin
                mon_e = exp_q.pop_front();
                chk("res_lo", mon_e.lo, res_lo);
                chk("res_hi", mon_e.hi, res_hi);
                chk("flags", {28'h0, mon_e.f}, {28'h0, un, ov, eq, cy});
            end
        end
    end
    initial begin
        rst_n_i = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h00000000;
        seed = 99320;
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(`SBA_REG_MASK, 32'h00000000);
        rd(`SBA_REG_FLAGS, 32'h00000020);
        rd(4'hC, 32'h00000000);
        $display("test reset values done");
        run(4'h1, 32'hAAAA7FFF, 32'h55550001);
        run(4'h1, 32'h00008000, 32'h0000FFFF);
        run(4'h2, 32'h00000000, 32'h00000001);
        run(4'h2, 32'h00008000, 32'h00000001);
        run(4'h0, 32'h00008000, 32'h00000000);
        run(4'h0, 32'hFFFF0000, 32'h00000000);
        run(4'h3, 32'h00008000, 32'h00008000);
        run(4'h4, 32'h0000FFF9, 32'h00000003);
        run(4'h4, 32'h00008000, 32'h0000FFFF);
        run(4'h4, 32'h00000007, 32'h00000000);
        run(4'h6, 32'h7FFFFFFF, 32'h00000001);
        run(4'h7, 32'h80000000, 32'h00000001);
        run(4'h5, 32'h80000000, 32'h00000000);
        run(4'h8, 32'h80000000, 32'h80000000);
        run(4'h9, 32'h80000000, 32'hFFFFFFFD);
        for (int c = 10; c < 16; c++) begin
            run(4'(c), 32'h00000001, 32'h00000001);
            seq_u.idle();
            chk("op_err", 32'h1, {31'h0, op_err});
        end
        drain();
        $display("test corner operations done");
        wr(`SBA_REG_STATUS, 32'h0000001F);
        run(4'h1, 32'h00007FFF, 32'h00000001);
        drain();
        rd(`SBA_REG_STATUS, 32'h00000003);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`SBA_REG_MASK, 32'h00000002);
        @(posedge clk_sys_i);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`SBA_REG_STATUS, 32'h00000002);
        @(posedge clk_sys_i);
        chk("irq", 32'h0, {31'h0, irq});
        rd(`SBA_REG_STATUS, 32'h00000001);
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, 32'h00000000);
        $display("test interrupt done");
        repeat (300) begin
            rnd = $random(seed);
            run(4'(rnd % 10), $random(seed), $random(seed));
        end
        drain();
        $display("test random operations done");
        end_sim();
    end
endmodule // tb_top
